// ### hw/lab_pkg.sv
// Purpose: Shared constants for the loop, AND and bit-operation execution block
// Assumes: 32-bit classic Wishbone register access, word-aligned offsets
// Notes:   Flag bit positions follow the core's flag register layout
package lab_pkg;
  localparam int          DATA_W     = 16;
  localparam int          PC_W       = 20;
  localparam int          FLAG_W     = 8;
  localparam int          IMM_W      = 4;
  localparam int          ADR_W      = 8;
  // Register offsets
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_SRC    = 8'h04;
  localparam logic [7:0]  OFS_DST    = 8'h08;
  localparam logic [7:0]  OFS_PC     = 8'h0c;
  localparam logic [7:0]  OFS_LABEL  = 8'h10;
  localparam logic [7:0]  OFS_FLAGS  = 8'h14;
  localparam logic [7:0]  OFS_STATUS = 8'h18;
  // Control fields
  localparam int          CT_OP      = 0;
  localparam int          CT_WORD    = 2;
  localparam int          CT_SHORT   = 3;
  localparam int          CT_SAREG   = 4;
  localparam int          CT_DAREG   = 5;
  localparam int          CT_SAME    = 6;
  localparam int          CT_SUB     = 7;
  localparam int          CT_SB11    = 8;
  localparam int          CT_BIT     = 12;
  localparam int          CT_W       = 16;
  // Status fields
  localparam int          ST_BRANCH  = 0;
  localparam int          ST_ILLEGAL = 1;
  localparam int          ST_DONE    = 2;
  // Flag positions
  localparam int          FL_C       = 0;
  localparam int          FL_Z       = 2;
  localparam int          FL_S       = 3;
  localparam int          FL_O       = 5;
  localparam logic [7:0]  FLAGS_RST  = 8'h00;
  // Branch window around the instruction start
  localparam int          BR_BACK    = 126;
  localparam int          BR_FWD     = 129;
  typedef enum logic [1:0] {
    LAB_OP_LOOP = 2'b00,
    LAB_OP_AND  = 2'b01,
    LAB_OP_BAND = 2'b10,
    LAB_OP_CLR  = 2'b11
  } lab_op_e;
endpackage

// ### hw/lab_exec.sv
// Purpose: One-cycle execution of loop add, AND, bit-AND-carry and bit clear
// Assumes: Operands are stable in the cycle start_i is high
// Notes:   All outputs registered; illegal forms write nothing back
`timescale 1ns/1ps
`default_nettype none
module lab_exec
  import lab_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  start_i,
  input  wire lab_pkg::lab_op_e      op_i,
  input  wire logic [lab_pkg::CT_W-1:0]   ctrl_i,
  input  wire logic [lab_pkg::DATA_W-1:0] src_i,
  input  wire logic [lab_pkg::DATA_W-1:0] dst_i,
  input  wire logic [lab_pkg::PC_W-1:0]   pc_i,
  input  wire logic [lab_pkg::PC_W-1:0]   label_i,
  input  wire logic [lab_pkg::FLAG_W-1:0] flags_i,
  output logic                       valid_o,
  output logic                       illegal_o,
  output logic                       branch_o,
  output logic [lab_pkg::DATA_W-1:0] result_o,
  output logic [lab_pkg::FLAG_W-1:0] flags_o
);
  wire              word_w  = ctrl_i[CT_WORD];
  wire              short_w = ctrl_i[CT_SHORT];
  wire              sareg_w = ctrl_i[CT_SAREG];
  wire              dareg_w = ctrl_i[CT_DAREG];
  wire [3:0]        bit_w   = ctrl_i[CT_BIT+:4];
  // Immediate is a 4-bit signed field, so it cannot leave -8..+7
  wire [15:0]       imm_w   = {{(DATA_W-IMM_W){src_i[IMM_W-1]}}, src_i[IMM_W-1:0]};
  wire [15:0]       sum_w   = ctrl_i[CT_SUB] ? dst_i - imm_w
                                             : dst_i + imm_w;
  wire [15:0]       loop_w  = word_w ? sum_w : {dst_i[15:8], sum_w[7:0]};
  wire              lzero_w = word_w ? (sum_w == 16'h0000) : (sum_w[7:0] == 8'h00);
  wire signed [20:0] dist_w = $signed({1'b0, label_i}) - $signed({1'b0, pc_i});
  wire              inwin_w = (dist_w >= -BR_BACK) && (dist_w <= BR_FWD);
  // Byte source from an address register keeps only its low byte
  wire [15:0]       asrc_w  = word_w ? src_i : {8'h00, src_i[7:0]};
  wire              wide_w  = word_w || dareg_w;
  wire [15:0]       andf_w  = dst_i & asrc_w;
  wire [15:0]       and_w   = wide_w ? andf_w : {dst_i[15:8], andf_w[7:0]};
  wire              asgn_w  = wide_w ? andf_w[15] : andf_w[7];
  wire              azero_w = wide_w ? (andf_w == 16'h0000) : (andf_w[7:0] == 8'h00);
  wire              bad_and = (!word_w && sareg_w && dareg_w)
                           || (short_w && word_w)
                           || (short_w && ctrl_i[CT_SAME]);
  wire              bad_w   = (op_i == LAB_OP_AND  && bad_and)
                           || (op_i == LAB_OP_CLR && ctrl_i[CT_SB11] && !short_w)
                           || (op_i == LAB_OP_LOOP && !inwin_w);
  logic [15:0]      nxt_res;
  logic [7:0]       nxt_flg;
  logic             nxt_br;
  always_comb begin
    nxt_res = dst_i;
    nxt_flg = flags_i;
    nxt_br  = 1'b0;
    case (op_i)
      LAB_OP_LOOP: begin
        nxt_res = loop_w;
        nxt_br  = !lzero_w;
      end
      LAB_OP_AND: begin
        nxt_res       = and_w;
        nxt_flg[FL_S] = asgn_w;
        nxt_flg[FL_Z] = azero_w;
      end
      LAB_OP_BAND: nxt_flg[FL_C] = src_i[bit_w] & flags_i[FL_C];
      default: nxt_res[bit_w] = 1'b0;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_o   <= 1'b0;
      illegal_o <= 1'b0;
      branch_o  <= 1'b0;
      result_o  <= 16'h0000;
      flags_o   <= FLAGS_RST;
    end else begin
      valid_o <= start_i;
      if (start_i) begin
        illegal_o <= bad_w;
        branch_o  <= nxt_br && !bad_w;
        result_o  <= bad_w ? dst_i : nxt_res;
        flags_o   <= bad_w ? flags_i : nxt_flg;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_LOOP_FLAGS: assert property (
      start_i && op_i == LAB_OP_LOOP |=> flags_o == $past(flags_i))
    else $error("loop op changed flags");
  AST_LOOP_BR: assert property (
      start_i && op_i == LAB_OP_LOOP && inwin_w && word_w
      |=> branch_o == (result_o != 16'h0000))
    else $error("loop branch does not follow sum");
  AST_WIN: assert property (
      start_i && op_i == LAB_OP_LOOP && !inwin_w |=> illegal_o && !branch_o)
    else $error("out of window target accepted");
  AST_AND_Z: assert property (
      start_i && op_i == LAB_OP_AND && !bad_w && word_w
      |=> flags_o[FL_Z] == (result_o == 16'h0000) && flags_o[FL_S] == result_o[15])
    else $error("AND flags wrong");
  AST_AND_CO: assert property (
      start_i && op_i == LAB_OP_AND
      |=> flags_o[FL_C] == $past(flags_i[FL_C]) && flags_o[FL_O] == $past(flags_i[FL_O]))
    else $error("AND touched carry or overflow");
  AST_BAND: assert property (
      start_i && op_i == LAB_OP_BAND && !flags_i[FL_C] |=> !flags_o[FL_C])
    else $error("bit-AND set carry from zero");
  AST_BIT_CLR: assert property (
      start_i && op_i == LAB_OP_CLR && !bad_w
      |=> result_o[$past(bit_w)] == 1'b0 && flags_o == $past(flags_i))
    else $error("bit clear failed");
  AST_SHORT: assert property (
      start_i && op_i == LAB_OP_AND && short_w && word_w |=> illegal_o)
    else $error("word short form accepted");
  COV_BR: cover property (start_i && op_i == LAB_OP_LOOP ##1 branch_o);
  COV_AND: cover property (start_i && op_i == LAB_OP_AND ##1 !illegal_o);
  COV_ILL: cover property (start_i ##1 illegal_o);
endmodule
`default_nettype wire

// ### hw/lab_top.sv
// Purpose: Wishbone-reached execution block for loop add, AND and bit ops
// Assumes: Classic single-cycle Wishbone master, synchronous active-high reset
// Notes:   A CTRL write with lane 0 launches one instruction; results land three edges later
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Loop add writes sum, flags unchanged
// - Branch when sum nonzero, else fall through
// - Add and subtract loop share opcode
// - Loop immediate signed, -8 to +7
// - Target within -126..+129 of instruction start
// - AND stores src AND dest, byte/word
// - Byte into address register: zero-extend source
// - Byte from address register: low byte only
// - Byte form forbids two address registers
// - AND sets sign from result MSB
// - AND sets zero; carry, overflow kept
// - Short AND form is byte only
// - Short form forbids same source, destination
// - Carry becomes selected bit AND carry
// - Bit clear writes zero to bit
// - Bit clear: static-base 11-bit bit address short only
module lab_top
  import lab_pkg::*;
#(
  parameter int ADDR_W = lab_pkg::ADR_W
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   branch_taken_o,
  output logic                   illegal_o
);
  import lab_pkg::*;

  // Refuse address widths under 6 bits, one bit more than the status offset needs
  if (ADDR_W < 6) begin : g_adr_chk
    $error("ADDR_W too narrow for the register map");
  end

  // Byte-lane merge shared by every writable register
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel_v
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel_v[i]) begin
        res[i*8+:8] = new_v[i*8+:8];
      end
    end
    return res;
  endfunction

  logic                ack_ff;
  logic [CT_W-1:0]     ctrl_ff;
  logic [DATA_W-1:0]   src_ff;
  logic [DATA_W-1:0]   dst_ff;
  logic [PC_W-1:0]     pc_ff;
  logic [PC_W-1:0]     label_ff;
  logic [FLAG_W-1:0]   flags_ff;
  logic                branch_ff;
  logic                illegal_ff;
  logic                done_ff;
  logic                start_ff;
  logic [31:0]         rdat_ff;

  wire                 ex_valid;
  wire                 ex_illegal;
  wire                 ex_branch;
  wire [DATA_W-1:0]    ex_result;
  wire [FLAG_W-1:0]    ex_flags;

  // Decode
  wire        req_w    = wb_cyc_i && wb_stb_i && !ack_ff;
  wire        wr_w     = req_w && wb_we_i;
  wire [7:0]  adr_w    = 8'(wb_adr_i);
  wire        hit_ctrl = adr_w == OFS_CTRL;
  wire        hit_src  = adr_w == OFS_SRC;
  wire        hit_dst  = adr_w == OFS_DST;
  wire        hit_pc   = adr_w == OFS_PC;
  wire        hit_lab  = adr_w == OFS_LABEL;
  wire        hit_flg  = adr_w == OFS_FLAGS;
  wire        hit_st   = adr_w == OFS_STATUS;
  wire [31:0] old_ctrl = {16'h0000, ctrl_ff};
  wire [31:0] new_ctrl = lane_merge(old_ctrl, wb_dat_i, wb_sel_i);
  wire [31:0] new_src  = lane_merge({16'h0000, src_ff}, wb_dat_i, wb_sel_i);
  wire [31:0] new_dst  = lane_merge({16'h0000, dst_ff}, wb_dat_i, wb_sel_i);
  wire [31:0] new_pc   = lane_merge({12'h000, pc_ff}, wb_dat_i, wb_sel_i);
  wire [31:0] new_lab  = lane_merge({12'h000, label_ff}, wb_dat_i, wb_sel_i);
  wire [31:0] new_flg  = lane_merge({24'h000000, flags_ff}, wb_dat_i, wb_sel_i);
  // Launch only when the low byte carrying the opcode is written
  wire        launch_w = wr_w && hit_ctrl && wb_sel_i[0];
  wire [31:0] status_w = {29'h0, done_ff, illegal_ff, branch_ff};
  wire [31:0] rmux_w   = hit_ctrl ? old_ctrl :
                         hit_src  ? {16'h0000, src_ff} :
                         hit_dst  ? {16'h0000, dst_ff} :
                         hit_pc   ? {12'h000, pc_ff} :
                         hit_lab  ? {12'h000, label_ff} :
                         hit_flg  ? {24'h000000, flags_ff} :
                         hit_st   ? status_w :
                         32'h00000000;

  // Wishbone answer: one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      ack_ff  <= req_w;
      rdat_ff <= req_w ? rmux_w : 32'h00000000;
    end
  end

  // Opcode shared by both loop forms; sub bit picks the variant
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= 16'h0000;
    end else if (wr_w && hit_ctrl) begin
      ctrl_ff <= new_ctrl[CT_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_ff   <= 16'h0000;
      pc_ff    <= 20'h00000;
      label_ff <= 20'h00000;
    end else if (wr_w) begin
      if (hit_src) begin
        src_ff <= new_src[DATA_W-1:0];
      end
      if (hit_pc) begin
        pc_ff <= new_pc[PC_W-1:0];
      end
      if (hit_lab) begin
        label_ff <= new_lab[PC_W-1:0];
      end
    end
  end

  // Commit of a finished instruction wins over a bus write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dst_ff   <= 16'h0000;
      flags_ff <= FLAGS_RST;
    end else if (ex_valid) begin
      dst_ff   <= ex_result;
      flags_ff <= ex_flags;
    end else if (wr_w) begin
      if (hit_dst) begin
        dst_ff <= new_dst[DATA_W-1:0];
      end
      if (hit_flg) begin
        flags_ff <= new_flg[FLAG_W-1:0];
      end
    end
  end

  // Status; done clears on the next launch, set wins over that clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_ff   <= 1'b0;
      branch_ff  <= 1'b0;
      illegal_ff <= 1'b0;
      done_ff    <= 1'b0;
    end else begin
      start_ff <= launch_w;
      if (ex_valid) begin
        branch_ff  <= ex_branch;
        illegal_ff <= ex_illegal;
        done_ff    <= 1'b1;
      end else if (launch_w) begin
        done_ff <= 1'b0;
      end
    end
  end

  // Operands sampled from registers the cycle after the launch
  lab_exec u_exec (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .start_i   (start_ff),
    .op_i      (lab_op_e'(ctrl_ff[CT_OP+:2])),
    .ctrl_i    (ctrl_ff),
    .src_i     (src_ff),
    .dst_i     (dst_ff),
    .pc_i      (pc_ff),
    .label_i   (label_ff),
    .flags_i   (flags_ff),
    .valid_o   (ex_valid),
    .illegal_o (ex_illegal),
    .branch_o  (ex_branch),
    .result_o  (ex_result),
    .flags_o   (ex_flags)
  );

  assign wb_ack_o       = ack_ff;
  assign wb_dat_o       = rdat_ff;
  assign branch_taken_o = branch_ff;
  assign illegal_o      = illegal_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_ONE: assert property (
      wb_cyc_i && wb_stb_i && !ack_ff |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after strobe");
  AST_LAUNCH_DONE: assert property (launch_w |-> ##3 done_ff)
    else $error("instruction did not complete in time");
  AST_LOOP_KEEP: assert property (
      start_ff && ctrl_ff[CT_OP+:2] == LAB_OP_LOOP
      ##1 ex_valid |=> flags_ff == $past(flags_ff, 2))
    else $error("loop instruction changed flags");
  AST_ILL_DST: assert property (
      ex_valid && ex_illegal |=> dst_ff == $past(dst_ff))
    else $error("illegal form wrote destination");
  AST_BR_ZERO: assert property (
      ex_valid && ex_branch |=> dst_ff != 16'h0000 || !ctrl_ff[CT_WORD])
    else $error("branch taken on zero sum");
  AST_SB11: assert property (
      start_ff && ctrl_ff[CT_OP+:2] == LAB_OP_CLR
      && ctrl_ff[CT_SB11] && !ctrl_ff[CT_SHORT] |=> ##1 illegal_ff)
    else $error("long static-base bit form accepted");
  AST_SAME: assert property (
      start_ff && ctrl_ff[CT_OP+:2] == LAB_OP_AND
      && ctrl_ff[CT_SHORT] && ctrl_ff[CT_SAME] |=> ##1 illegal_ff)
    else $error("short form with same register accepted");
  AST_BYTE_AREG: assert property (
      start_ff && ctrl_ff[CT_OP+:2] == LAB_OP_AND
      && !ctrl_ff[CT_WORD] && ctrl_ff[CT_SAREG] && ctrl_ff[CT_DAREG] |=> ##1 illegal_ff)
    else $error("byte form with two address registers accepted");

  COV_LOOP_DONE: cover property (launch_w ##3 done_ff && branch_ff);
  COV_UNMAPPED: cover property (req_w && !(hit_ctrl || hit_src || hit_dst || hit_pc
    || hit_lab || hit_flg || hit_st));
endmodule
`default_nettype wire

// ### sim/lab_seq_model.sv
// Purpose: Wishbone master standing in for the core's sequencer
// Assumes: Classic single cycles, one request at a time
// Notes:   Released address and data show inverted values, never stale ones
`timescale 1ns/1ps
`default_nettype none
module lab_seq_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  int tmo_cnt = 0;
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // Bounded wait: a missing answer is counted, not hung on
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      input logic [3:0] s, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 64);
    if (ack_i !== 1'b1)
      tmo_cnt++;
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~wd;
  endtask
endmodule
`default_nettype wire

// ### sim/test_logic_add_branch_bit_ops.sv
// Purpose: Self-checking bench for the loop, AND and bit-operation block
// Assumes: Register map and three-edge commit as handed over
// Notes:   Reference model works in ints; random mix from an xorshift
`timescale 1ns/1ps
`default_nettype none
module test_logic_add_branch_bit_ops;
  import lab_pkg::*;
  localparam int PCB = 4096;
  logic        clk_i;
  logic        rst_i = 1'b1;
  wire logic   cyc;
  wire logic   stb;
  wire logic   we;
  wire logic [7:0]  adr;
  wire logic [3:0]  sel;
  wire logic [31:0] wdat;
  wire logic [31:0] rdat;
  wire logic   ack;
  wire logic   brt;
  wire logic   ill;
  logic [31:0] seed = 32'h1df1;
  logic [31:0] rv;
  logic [31:0] r2;
  logic [15:0] c;
  int          pc;
  int          error_cnt = 0;
  int          checks_done = 0;
  logic [31:0] exp_q[$];
  lab_top #(.ADDR_W(ADR_W)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .branch_taken_o(brt), .illegal_o(ill));
  lab_seq_model seq (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic summarize();
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Reads drive random lanes and data: the slave must ignore both
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    rv = rnd();
    seq.xfer(w, a, w ? d : rv, w ? 4'hf : rv[3:0], rv);
    if (seq.tmo_cnt != 0) begin
      error_cnt++;
      summarize();
    end
  endtask
  task automatic run(input logic [15:0] k, input logic [15:0] s, input logic [15:0] d,
                     input int p, input int lab, input logic [7:0] fl);
    int          imm;
    int          sum;
    int          n;
    logic [15:0] r;
    logic [7:0]  f;
    logic        il;
    logic        br;
    logic        wide;
    r = d;
    f = fl;
    br = 1'b0;
    wide = k[CT_WORD] | k[CT_DAREG];
    il = (k[1:0] == 2'h1) && ((!k[CT_WORD] && k[CT_SAREG] && k[CT_DAREG]) ||
      (k[CT_SHORT] && (k[CT_WORD] || k[CT_SAME])));
    il = il || (k[1:0] == 2'h3 && k[CT_SB11] && !k[CT_SHORT]);
    case (k[1:0])
      2'h0: begin
        imm = s[3] ? int'(s[3:0]) - 16 : int'(s[3:0]);
        sum = k[CT_SUB] ? int'(d) - imm : int'(d) + imm;
        r = k[CT_WORD] ? sum[15:0] : {d[15:8], sum[7:0]};
        br = k[CT_WORD] ? (r != 16'h0) : (r[7:0] != 8'h00);
        il = il || (lab - p < -BR_BACK) || (lab - p > BR_FWD);
      end
      2'h1: begin
        r = k[CT_WORD] ? s & d : k[CT_DAREG] ? {8'h00, s[7:0]} & d : {d[15:8], s[7:0] & d[7:0]};
        f[FL_S] = wide ? r[15] : r[7];
        f[FL_Z] = wide ? (r == 16'h0) : (r[7:0] == 8'h00);
      end
      2'h2: f[FL_C] = s[k[15:12]] & fl[FL_C];
      default: r[k[15:12]] = 1'b0;
    endcase
    if (il) begin
      r = d;
      f = fl;
      br = 1'b0;
    end
    exp_q.push_back({29'h0, 1'b1, il, br});
    exp_q.push_back({16'h0, r});
    exp_q.push_back({24'h0, f});
    bus(1'b1, OFS_SRC, {16'h0, s});
    bus(1'b1, OFS_DST, {16'h0, d});
    bus(1'b1, OFS_PC, 32'(p));
    bus(1'b1, OFS_LABEL, 32'(lab));
    bus(1'b1, OFS_FLAGS, {24'h0, fl});
    bus(1'b1, OFS_CTRL, {16'h0, k});
    n = 0;
    do begin
      bus(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rv[ST_DONE] !== 1'b1 && n < 8);
    if (rv[ST_DONE] !== 1'b1) begin
      error_cnt++;
      summarize();
    end
    cmp32(rv, exp_q.pop_front());
    cmp1(brt, br);
    cmp1(ill, il);
    bus(1'b0, OFS_DST, 32'h0);
    cmp32(rv, exp_q.pop_front());
    bus(1'b0, OFS_FLAGS, 32'h0);
    cmp32(rv, exp_q.pop_front());
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b1, 8'h1c, 32'hffffffff);
    for (int a = 0; a <= 28; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      cmp32(rv, 32'h0);
    end
    run(16'h0004, 16'h000f, 16'h0001, PCB, PCB - 126, 8'ha5);
    run(16'h0004, 16'h0008, 16'h0005, PCB, PCB + 129, 8'h5a);
    run(16'h0004, 16'h0007, 16'hfff9, PCB, PCB + 16, 8'hff);
    run(16'h0004, 16'h0001, 16'h0003, PCB, PCB + 130, 8'h00);
    run(16'h0004, 16'h0001, 16'h0003, PCB, PCB - 127, 8'h00);
    run(16'h0000, 16'h0001, 16'h12ff, PCB, PCB + 4, 8'h2d);
    run(16'h0084, 16'h0003, 16'h0003, PCB, PCB + 4, 8'h00);
    run(16'h0084, 16'h000d, 16'h0003, PCB, PCB + 4, 8'h00);
    run(16'h0005, 16'h8f0f, 16'hf0f0, PCB, PCB, 8'h24);
    run(16'h0005, 16'h0f0f, 16'hf0f0, PCB, PCB, 8'h21);
    run(16'h0021, 16'hff80, 16'hffff, PCB, PCB, 8'h08);
    run(16'h0011, 16'hff80, 16'h12ff, PCB, PCB, 8'h04);
    run(16'h0031, 16'h00ff, 16'h00ff, PCB, PCB, 8'h00);
    run(16'h0009, 16'h0001, 16'h0003, PCB, PCB, 8'h00);
    run(16'h000d, 16'h0001, 16'h0003, PCB, PCB, 8'h00);
    run(16'h0049, 16'h0001, 16'h0003, PCB, PCB, 8'h00);
    run(16'h5103, 16'h0000, 16'hffff, PCB, PCB, 8'h00);
    run(16'h510b, 16'h0000, 16'hffff, PCB, PCB, 8'h00);
    for (int b = 0; b < 16; b++) begin
      r2 = rnd();
      run({b[3:0], 12'h002}, r2[15:0], r2[31:16], PCB, PCB, r2[7:0]);
      run({b[3:0], 12'h003}, r2[31:16], r2[15:0], PCB, PCB, r2[15:8]);
    end
    // Mixed forms: masks keep fields the op does not use at zero
    for (int i = 0; i < 60; i++) begin
      r2 = rnd();
      c = r2[15:0] & ((r2[1:0] == 2'h0) ? 16'h0084 : (r2[1:0] == 2'h1) ? 16'h007f :
        (r2[1:0] == 2'h2) ? 16'hf003 : 16'hf10b);
      pc = 2048 + int'(r2[26:16]);
      run(c, 16'(rnd() >> 16), 16'(rnd() >> 8), pc, pc + int'(r2[31:23]) - 200,
          r2[23:16]);
    end
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    cmp1(brt, 1'b0);
    cmp1(ill, 1'b0);
    bus(1'b0, OFS_STATUS, 32'h0);
    cmp32(rv, 32'h0);
    bus(1'b0, OFS_DST, 32'h0);
    cmp32(rv, 32'h0);
    bus(1'b0, OFS_FLAGS, 32'h0);
    cmp32(rv, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
